// ### core/dac_device_end.sv
// Converter digital interface: registers, sample transfer and interrupt.
// Assumes the link request is a one-cycle pulse on clock_i.
// Notes on behaviour
// - Two identical instances, each own base address.
// - Convert only after power enable and startup.
// - Output level is reference times code/1024.
// - Output register written only from holding register; a write that meets a trigger edge is taken straight through.
// - Trigger off: copy one cycle after write.
// - Trigger on: copy only on timer trigger.
// - Select codes 0-5 pick timer; 11x reserved.
// - Each rising timer edge copies latest holding.
// - Software sets selected timer to waveform mode.
// - Resolution bit 1 shifts data left two.
// - Eight-bit mode bytes, ten-bit mode half-words.
// - Holding reads adjusted value, upper bits zero.
// - Output register read-only, right-aligned, zero-padded.
// - Ready flag low while written data waits.
// - Ready low when trigger off; enabling sets it.
// - Interrupt request raised from ready status.
// - Enable register bit 0 enables interrupt.
// - Disable register bit 0 disables interrupt.
// - Soft reset bit resets interface logic.
// - Mask view reads interrupt enable state.
`timescale 1ns/1ns
`include "dac_params.svh"
module dac_device_end #(
	parameter logic [31:0] BASE_ADDR = `DAC0_BASE,
	parameter int DATA_W = `DAC_DATA_W
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Register link
	dac_link_if.dev link,
	// Power manager and timers
	input wire logic power_enable_i,
	input wire logic [`DAC_TIMER_N-1:0] timer_out_i,
	// Converter side
	output logic [DATA_W-1:0] sample_o,
	output logic conv_ready_o,
	output logic irq_o
);
	logic hit;
	logic soft_rst;
	logic trg_en;
	logic [2:0] trg_sel;
	logic res_8bit;
	logic [DATA_W-1:0] hold;
	logic copy_pend;
	logic data_ready;
	logic irq_mask;
	logic trig;
	logic hold_wr;
	logic mode_wr;
	logic new_trg_en;
	logic [DATA_W-1:0] hold_in;
	logic [`DAC_TIMER_N-1:0] tmr_rise;
	logic [`DAC_CNT_W-1:0] start_cnt;
	logic [31:0] read_val;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// base address match
	assign hit = (link.addr & `DAC_BASE_MASK) == (BASE_ADDR & `DAC_BASE_MASK);

	function automatic logic is_write(input logic [4:0] target);
		is_write = link.req && link.wr && hit && (link.addr[4:0] == target);
	endfunction : is_write

	function automatic logic [DATA_W-1:0] adjust(input logic res, input logic [31:0] wd);
		if (res)
			adjust = {wd[DATA_W-`DAC_RES_SHIFT-1:0], {`DAC_RES_SHIFT{1'b0}}};
		else
			adjust = wd[DATA_W-1:0];
	endfunction : adjust

	assign soft_rst = is_write(`DAC_OFS_CTRL) && link.wdata[`DAC_BIT_SOFT_RESET_CMD];
	assign mode_wr = is_write(`DAC_OFS_MODE);
	assign new_trg_en = link.wdata[`DAC_BIT_TIMER_TRIGGER_ENABLE];
	assign hold_wr = is_write(`DAC_OFS_HOLD);
	assign hold_in = adjust(res_8bit, link.wdata);

	// ----------------------------------------
	// Timer trigger
	// ----------------------------------------
	dac_edge_sync #(
		.WIDTH(`DAC_TIMER_N)
	) u_sync (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.async_i(timer_out_i),
		.rise_o(tmr_rise)
	);

	assign trig = trg_en && (trg_sel <= `DAC_SEL_LAST) && tmr_rise[trg_sel];

	// ----------------------------------------
	// Mode register
	// ----------------------------------------
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			trg_en <= 1'b0;
			trg_sel <= 3'h0;
			res_8bit <= 1'b0;
		end
		else if (soft_rst)
		begin
			trg_en <= 1'b0;
			trg_sel <= 3'h0;
			res_8bit <= 1'b0;
		end
		else if (mode_wr)
		begin
			trg_en <= new_trg_en;
			trg_sel <= link.wdata[`DAC_SEL_MSB:`DAC_SEL_LSB];
			res_8bit <= link.wdata[`DAC_BIT_RES];
		end
	end

	// ----------------------------------------
	// Holding and output registers
	// ----------------------------------------
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			hold <= '0;
		else if (soft_rst)
			hold <= '0;
		else if (hold_wr)
			hold <= hold_in;
	end

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			copy_pend <= 1'b0;
		else
			copy_pend <= hold_wr && !trg_en && !soft_rst;
	end

	// A write that meets a trigger edge is taken straight through.
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			sample_o <= '0;
		else if (soft_rst)
			sample_o <= '0;
		else if (trig)
			sample_o <= hold_wr ? hold_in : hold;
		else if (copy_pend && !trg_en)
			sample_o <= hold;
	end

	// ----------------------------------------
	// Ready flag and interrupt
	// ----------------------------------------
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			data_ready <= 1'b0;
		else if (soft_rst)
			data_ready <= 1'b0;
		else if (mode_wr && (new_trg_en != trg_en))
			data_ready <= new_trg_en;
		else if (!trg_en)
			data_ready <= 1'b0;
		// set on transfer, clear on write
		else if (trig)
			data_ready <= 1'b1;
		else if (hold_wr)
			data_ready <= 1'b0;
	end

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			irq_mask <= 1'b0;
		else if (soft_rst)
			irq_mask <= 1'b0;
		else if (is_write(`DAC_OFS_IDIS) && link.wdata[`DAC_BIT_DATA_READY_FLAG])
			irq_mask <= 1'b0;
		else if (is_write(`DAC_OFS_IEN) && link.wdata[`DAC_BIT_DATA_READY_FLAG])
			irq_mask <= 1'b1;
	end

	assign irq_o = data_ready && irq_mask;
	assign link.irq = irq_o;

	// ----------------------------------------
	// Startup after power enable
	// ----------------------------------------
	// startup interval before converting
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			start_cnt <= '0;
		else if (!power_enable_i)
			start_cnt <= '0;
		else if (start_cnt < `DAC_CNT_W'(`DAC_STARTUP_CYC))
			start_cnt <= start_cnt + `DAC_CNT_W'(1);
	end

	// converter ready while power is enabled and the startup count has been reached
	assign conv_ready_o = power_enable_i && (start_cnt == `DAC_CNT_W'(`DAC_STARTUP_CYC));

	// ----------------------------------------
	// Read path and answer
	// ----------------------------------------
	always_comb
	begin
		read_val = `DAC_ZERO32;
		case (link.addr[4:0])
			`DAC_OFS_MODE:
			begin
				read_val[`DAC_BIT_TIMER_TRIGGER_ENABLE] = trg_en;
				read_val[`DAC_SEL_MSB:`DAC_SEL_LSB] = trg_sel;
				read_val[`DAC_BIT_RES] = res_8bit;
			end
			`DAC_OFS_HOLD: read_val[DATA_W-1:0] = hold;
			`DAC_OFS_OUT: read_val[DATA_W-1:0] = sample_o;
			`DAC_OFS_STAT: read_val[`DAC_BIT_DATA_READY_FLAG] = data_ready;
			`DAC_OFS_IMASK: read_val[`DAC_BIT_DATA_READY_FLAG] = irq_mask;
			default: read_val = `DAC_ZERO32;
		endcase
	end

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			link.ack <= 1'b0;
			link.rdata <= `DAC_ZERO32;
		end
		else
		begin
			link.ack <= link.req;
			if (link.req)
				link.rdata <= (hit && !link.wr) ? read_val : `DAC_ZERO32;
		end
	end
endmodule : dac_device_end

// ### core/dac_params.svh
// Constants shared by both ends of the converter link.
// Assumes a 10 MHz main clock and 32-bit register words.
`ifndef DAC_PARAMS_SVH
`define DAC_PARAMS_SVH
`define DAC0_BASE 32'hFFFA8000
`define DAC1_BASE 32'hFFFAC000
`define DAC_BASE_MASK 32'hFFFFFFE0
`define DAC_OFS_CTRL 5'h00
`define DAC_OFS_MODE 5'h04
`define DAC_OFS_HOLD 5'h08
`define DAC_OFS_OUT 5'h0C
`define DAC_OFS_STAT 5'h10
`define DAC_OFS_IEN 5'h14
`define DAC_OFS_IDIS 5'h18
`define DAC_OFS_IMASK 5'h1C
`define DAC_BIT_SOFT_RESET_CMD 0
`define DAC_BIT_TIMER_TRIGGER_ENABLE 0
`define DAC_SEL_LSB 1
`define DAC_SEL_MSB 3
`define DAC_BIT_RES 4
`define DAC_BIT_DATA_READY_FLAG 0
`define DAC_SEL_LAST 3'h5
`define DAC_TIMER_N 6
`define DAC_DATA_W 10
`define DAC_RES_SHIFT 2
`define DAC_FULL_SCALE 1024
`define DAC_ZERO32 32'h00000000
`define DAC_STARTUP_NS 5000
`define DAC_CLK_NS 100
`define DAC_STARTUP_CYC ((`DAC_STARTUP_NS + `DAC_CLK_NS - 1) / `DAC_CLK_NS)
`define DAC_CNT_W 8
`define DAC_H_OFS_ADDR 8'h00
`define DAC_H_OFS_WDATA 8'h04
`define DAC_H_OFS_CMD 8'h08
`define DAC_H_OFS_RDATA 8'h0C
`define DAC_H_OFS_STAT 8'h10
`define DAC_H_BIT_CMD_WR 0
`define DAC_H_BIT_BUSY 0
`define DAC_H_BIT_IRQ 1
`define DAC_H_BIT_READY 2
`define DAC_HALF_W 16
`endif

// ### core/dac_pkg.sv
// Types used by the controller end of the converter link.
// Assumes nothing of its surroundings.
package dac_pkg;
	typedef enum logic [1:0] {
		CS_START = 2'b00,
		CS_IDLE = 2'b01,
		CS_ISSUE = 2'b10,
		CS_WAIT = 2'b11
	} dac_ctl_state_type;
endpackage : dac_pkg

// ### core/dac_link_if.sv
// Register link between the converter and its controller.
// Assumes both ends run on the same main clock.
`timescale 1ns/1ns
interface dac_link_if;
	logic req;
	logic wr;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic ack;
	logic [31:0] rdata;
	logic irq;
	modport dev (input req, input wr, input addr, input wdata, output ack, output rdata, output irq);
	modport ctl (output req, output wr, output addr, output wdata, input ack, input rdata, input irq);
endinterface : dac_link_if

// ### core/dac_edge_sync.sv
// Two-stage synchroniser with rising-edge detection per bit.
// Assumes inputs are asynchronous to clock_i.
`timescale 1ns/1ns
module dac_edge_sync #(
	parameter int WIDTH = 6
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Pins and edges
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] rise_o
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end
		else
		begin
			stage1 <= async_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	assign rise_o = stage2 & ~stage3;
endmodule : dac_edge_sync

// ### core/dac_ctl_end.sv
// Controller end: APB slave registers that issue accesses over the link.
// Assumes one main clock shared with the converter end.
`timescale 1ns/1ns
`include "dac_params.svh"
module dac_ctl_end (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Register link
	dac_link_if.ctl link,
	// Status
	output logic irq_o
);
	dac_pkg::dac_ctl_state_type state;
	logic [31:0] addr_reg;
	logic [31:0] wdata_reg;
	logic [31:0] rdata_reg;
	logic wr_flag;
	logic [`DAC_CNT_W-1:0] start_cnt;
	logic apb_wr;
	logic cmd_go;

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign apb_wr = psel && penable && pwrite;
	assign cmd_go = apb_wr && (paddr[7:0] == `DAC_H_OFS_CMD) && (state == dac_pkg::CS_IDLE);

	// ----------------------------------------
	// Orders from software
	// ----------------------------------------
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			addr_reg <= `DAC_ZERO32;
			wdata_reg <= `DAC_ZERO32;
			wr_flag <= 1'b0;
		end
		else if (apb_wr)
		begin
			if (paddr[7:0] == `DAC_H_OFS_ADDR)
				addr_reg <= pwdata;
			if (paddr[7:0] == `DAC_H_OFS_WDATA)
				wdata_reg <= pwdata;
			if (cmd_go)
				wr_flag <= pwdata[`DAC_H_BIT_CMD_WR];
		end
	end

	// ----------------------------------------
	// Link sequencer
	// ----------------------------------------
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			state <= dac_pkg::CS_START;
			start_cnt <= '0;
			rdata_reg <= `DAC_ZERO32;
		end
		else
		begin
			case (state)
				dac_pkg::CS_START:
				begin
					start_cnt <= start_cnt + `DAC_CNT_W'(1);
					if (start_cnt == `DAC_CNT_W'(`DAC_STARTUP_CYC - 1))
						state <= dac_pkg::CS_IDLE;
				end
				dac_pkg::CS_IDLE:
				begin
					if (cmd_go)
						state <= dac_pkg::CS_ISSUE;
				end
				dac_pkg::CS_ISSUE: state <= dac_pkg::CS_WAIT;
				dac_pkg::CS_WAIT:
				begin
					if (link.ack)
					begin
						rdata_reg <= link.rdata;
						state <= dac_pkg::CS_IDLE;
					end
				end
				default: state <= dac_pkg::CS_IDLE;
			endcase
		end
	end

	assign link.req = (state == dac_pkg::CS_ISSUE);
	assign link.wr = wr_flag;
	assign link.addr = addr_reg;
	// write data passes its low 16 bits to any register, upper bits zero
	assign link.wdata = {{(32-`DAC_HALF_W){1'b0}}, wdata_reg[`DAC_HALF_W-1:0]};
	assign irq_o = link.irq;

	// ----------------------------------------
	// APB read data
	// ----------------------------------------
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			prdata <= `DAC_ZERO32;
		else if (psel && !penable)
		begin
			case (paddr[7:0])
				`DAC_H_OFS_ADDR: prdata <= addr_reg;
				`DAC_H_OFS_WDATA: prdata <= wdata_reg;
				`DAC_H_OFS_RDATA: prdata <= rdata_reg;
				`DAC_H_OFS_STAT:
				begin
					prdata <= `DAC_ZERO32;
					prdata[`DAC_H_BIT_BUSY] <= (state != dac_pkg::CS_IDLE);
					prdata[`DAC_H_BIT_IRQ] <= link.irq;
					prdata[`DAC_H_BIT_READY] <= (state != dac_pkg::CS_START);
				end
				default: prdata <= `DAC_ZERO32;
			endcase
		end
	end
endmodule : dac_ctl_end

// ### verif/dac_link_assertions.sv
// Checks on the register link between the two converter ends.
// Assumes the device end answers at the first base address.
`timescale 1ns/1ns
`include "dac_params.svh"
module dac_link_assertions (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Link signals
	input wire logic req,
	input wire logic wr,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic ack,
	input wire logic [31:0] rdata,
	input wire logic irq
);
	default clocking dcb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);
	logic hit;
	logic [4:0] ofs;
	assign hit = req && ((addr & `DAC_BASE_MASK) == `DAC0_BASE);
	assign ofs = addr[4:0];
	AST_ACK_NEXT: assert property (req |=> ack)
		else $error("no ack after request");
	AST_ACK_PULSE: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	AST_REQ_GAP: assert property (req |=> !req [*2])
		else $error("requests too close");
	AST_HOLD_RD: assert property (hit && !wr && ofs == 5'h08 |=> rdata[31:10] == 22'h0)
		else $error("holding read upper bits set");
	AST_OUT_RD: assert property (hit && !wr && ofs == 5'h0C |=> rdata[31:10] == 22'h0)
		else $error("output read upper bits set");
	AST_IDIS_IRQ: assert property (hit && wr && ofs == 5'h18 && wdata[0] |=> !irq)
		else $error("irq after disable");
	AST_SOFT_RESET_CMD_IRQ: assert property (hit && wr && ofs == 5'h00 && wdata[0] |=> !irq)
		else $error("irq after soft reset");
	AST_HOLD_WR_IRQ: assert property (hit && wr && ofs == 5'h08 |=> !irq)
		else $error("irq while sample waits");
endmodule : dac_link_assertions

// ### verif/dac_digital_interface_tb_top.sv
// Bench joining the APB controller end to the converter device end.
// Assumes the design files under core are compiled first.
`timescale 1ns/1ns
`include "dac_params.svh"
module dac_digital_interface_tb_top;
	logic clock_i, sys_rst_i, psel, penable, pwrite, power_enable_i, pready, pslverr, irq_o, dirq, crdy;
	logic [31:0] paddr, pwdata, prdata, r, p;
	logic [5:0] timer_out_i;
	logic [9:0] sample_o;
	int error_cnt, checks;
	dac_link_if link ();
	dac_ctl_end u_dac_ctl_end (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link), .irq_o(irq_o));
	dac_device_end u_dac_device_end (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .link(link),
		.power_enable_i(power_enable_i), .timer_out_i(timer_out_i), .sample_o(sample_o),
		.conv_ready_o(crdy), .irq_o(dirq));
	dac_link_assertions u_dac_link_assertions (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .req(link.req),
		.wr(link.wr), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata), .irq(link.irq));
	// ----
	// Shared tasks
	// ----
	task print_verdict;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			$display("[ERR] %s exp %h got %h", n, e, g);
			error_cnt++;
		end
	endtask : chk
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge clock_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock_i);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			chk("pready", 32'h1, 32'h0);
			print_verdict;
		end
		// Step off the edge so that later looks at outputs see settled values.
		#1;
	endtask : apb
	// Polls the controller status until bit b equals v.
	task poll(input int b, input logic v);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, 32'h10, 32'h0);
			n++;
		end
		while (r[b] !== v && n < 40);
		if (r[b] !== v)
		begin
			chk("status_wait", 32'(v), r);
			print_verdict;
		end
	endtask : poll
	task dev(input logic w, input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, 32'h0, a);
		apb(1'b1, 32'h4, d);
		apb(1'b1, 32'h8, {31'h0, w});
		poll(0, 1'b0);
		if (!w)
			apb(1'b0, 32'hC, 32'h0);
	endtask : dev
	task wd(input logic [4:0] o, input logic [31:0] d);
		dev(1'b1, `DAC0_BASE + o, d);
	endtask : wd
	task rdc(input string n, input logic [4:0] o, input logic [31:0] e);
		dev(1'b0, `DAC0_BASE + o, 32'h0);
		chk(n, e, r);
	endtask : rdc
	task tick(input logic [5:0] m);
		@(posedge clock_i);
		timer_out_i <= m;
		repeat (3) @(posedge clock_i);
		timer_out_i <= 6'h00;
		repeat (6) @(posedge clock_i);
	endtask : tick
	// ----
	// Scenarios
	// ----
	task t_start;
		chk("conv_ready_early", 32'h0, crdy);
		poll(2, 1'b1);
		chk("conv_ready", 32'h1, crdy);
		rdc("mode_rst", 5'h04, 32'h0);
		rdc("stat_rst", 5'h10, 32'h0);
		rdc("ctrl_rd", 5'h00, 32'h0);
		rdc("mask_rst", 5'h1C, 32'h0);
	endtask : t_start
	task t_direct;
		wd(5'h08, 32'h7FF);
		chk("sample", 32'h3FF, sample_o);
		rdc("hold", 5'h08, 32'h3FF);
		rdc("out", 5'h0C, 32'h3FF);
		rdc("stat_off", 5'h10, 32'h0);
		wd(5'h0C, 32'h155);
		rdc("out_ro", 5'h0C, 32'h3FF);
		wd(5'h04, 32'h10);
		wd(5'h08, 32'h1AB);
		rdc("hold8", 5'h08, 32'h2AC);
		chk("sample8", 32'h2AC, sample_o);
	endtask : t_direct
	task t_trig;
		int s;
		p = 32'h2AC;
		for (s = 0; s < 7; s++)
		begin
			wd(5'h04, 32'h0);
			wd(5'h04, {28'h0, s[2:0], 1'b1});
			rdc("rdy_set", 5'h10, 32'h1);
			wd(5'h08, 32'h100 + s);
			rdc("rdy_wait", 5'h10, 32'h0);
			chk("held", p, sample_o);
			tick(s < 6 ? 6'h01 << s : 6'h3F);
			if (s < 6)
				p = 32'h100 + s;
			chk("moved", p, sample_o);
		end
	endtask : t_trig
	task t_irq;
		wd(5'h04, 32'h0);
		wd(5'h04, 32'h1);
		wd(5'h14, 32'h0);
		rdc("mask_zero", 5'h1C, 32'h0);
		wd(5'h14, 32'h1);
		rdc("mask_on", 5'h1C, 32'h1);
		chk("irq_on", 32'h1, dirq);
		chk("ctl_irq", 32'h1, irq_o);
		wd(5'h08, 32'h55);
		chk("irq_wait", 32'h0, dirq);
		tick(6'h01);
		chk("irq_back", 32'h1, dirq);
		wd(5'h18, 32'h0);
		rdc("mask_kept", 5'h1C, 32'h1);
		wd(5'h18, 32'h1);
		rdc("mask_off", 5'h1C, 32'h0);
		chk("irq_off", 32'h0, irq_o);
	endtask : t_irq
	task t_soft_reset_cmd;
		wd(5'h04, 32'h10);
		wd(5'h14, 32'h1);
		wd(5'h00, 32'h0);
		rdc("mode_kept", 5'h04, 32'h10);
		wd(5'h00, 32'h1);
		rdc("mode_clr", 5'h04, 32'h0);
		rdc("hold_clr", 5'h08, 32'h0);
		rdc("mask_clr", 5'h1C, 32'h0);
		chk("sample_clr", 32'h0, sample_o);
		dev(1'b1, `DAC1_BASE + 32'h4, 32'h10);
		rdc("base_other", 5'h04, 32'h0);
	endtask : t_soft_reset_cmd
	initial
	begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	initial
	begin
		sys_rst_i = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		power_enable_i = 1'b1;
		timer_out_i = 6'h00;
		error_cnt = 0;
		checks = 0;
		repeat (8) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		t_start;
		t_direct;
		t_trig;
		t_irq;
		t_soft_reset_cmd;
		print_verdict;
	end
endmodule : dac_digital_interface_tb_top
